/* File: rtl/ext_bus_strobe_lanes.v */
`timescale 1ns/1ps
`include "strobe_lanes_map.vh"
module ext_bus_strobe_lanes (
  input wire clk,
  input wire rst_n,
  input wire [1:0] acc_kind,
  input wire [2:0] acc_area,
  input wire acc_wide,
  input wire [1:0] acc_lanes,
  input wire acc_write,
  input wire acc_hbs_mode,
  input wire dram_two_we,
  input wire dram_phase,
  input wire [1:0] parity_check_sel,
  input wire addr_lsb_in,
  input wire [15:0] wr_data,
  input wire [1:0] wr_parity,
  output reg [7:0] area_selects_n,
  output reg row_strobe_n,
  output reg column_strobe_upper_n,
  output reg column_strobe_lower_n,
  output reg read_strobe_n,
  output reg upper_lane_strobe_n,
  output reg lower_lane_strobe_n,
  output reg addr_lsb,
  output reg addr_hold_strobe_n,
  output reg [15:0] data_out,
  output reg [1:0] data_oe,
  output reg upper_parity_line_out,
  output reg upper_parity_line_oe,
  output reg lower_parity_line_out,
  output reg lower_parity_line_oe
);
  // -----------------------------------------------------------------
  // next-state nets
  // -----------------------------------------------------------------
  // every _d value below is the level that the pin takes at the next
  // clock edge, so all pins change together one cycle after a request
  wire upper_on;
  wire lower_on;
  wire [7:0] area_hit;
  reg [7:0] area_selects_d;
  reg row_d;
  reg cas_u_d;
  reg cas_l_d;
  reg rd_d;
  reg wru_d;
  reg wrl_d;
  reg lsb_d;
  reg [1:0] doe_d;
  reg par_u_d;
  reg par_l_d;
  wire is_ext = (acc_kind == `KIND_EXT);
  wire is_dram = (acc_kind == `KIND_DRAM);
  wire col = is_dram && (dram_phase == `PHASE_COL);
  wire par_dram = parity_check_sel[0];
  wire par_area2 = parity_check_sel[1];

  // -----------------------------------------------------------------
  // byte lane decode
  // -----------------------------------------------------------------
  // a byte-wide space folds every access onto the low lane; the lane
  // enables below use upper_on and lower_on, the strobes also test acc_wide
  lane_select u_lanes (
    .wide_space(acc_wide),
    .lanes(acc_lanes),
    .addr_lsb(addr_lsb_in),
    .upper_on(upper_on),
    .lower_on(lower_on)
  );

  // -----------------------------------------------------------------
  // strobe decode
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `AREA_COUNT; g = g + 1) begin : g_area
      assign area_hit[g] = is_ext && (acc_area == g);
    end
  endgenerate

  // -----------------------------------------------------------------
  // combined strobe and lane logic
  // -----------------------------------------------------------------
  // one process owns area_selects_d so that the area 1 pin sharing
  // below can override the plain decode without a second driver
  always @* begin
    area_selects_d = ~area_hit;
    // ---------------------------------------------------------------
    // dram address strobes
    // ---------------------------------------------------------------
    // row strobe
    row_d = ~is_dram;
    // lower column strobe
    // two-write-strobe parts latch both bytes on the lower column strobe,
    // so it is asserted for upper-byte accesses there as well
    cas_l_d = ~(col && (lower_on || (acc_wide && dram_two_we)));
    cas_u_d = ~(col && acc_wide && !dram_two_we && upper_on);
    // ---------------------------------------------------------------
    // read and write strobes
    // ---------------------------------------------------------------
    // the read strobe is common to both kinds of space
    rd_d = ~((is_ext || is_dram) && !acc_write);
    wru_d = 1'b1;
    wrl_d = 1'b1;
    lsb_d = addr_lsb_in;
    if (is_dram && acc_write) begin
      if (acc_wide && dram_two_we) begin
        wru_d = ~upper_on;
        wrl_d = ~lower_on;
      end else begin
        wrl_d = 1'b0;
      end
    end else if (is_ext) begin
      if (!acc_wide) begin
        wrl_d = ~acc_write;
      end else if (acc_hbs_mode) begin
        wru_d = ~lower_on;
        wrl_d = ~acc_write;
        lsb_d = ~upper_on;
      end else if (acc_write) begin
        wru_d = ~upper_on;
        wrl_d = ~lower_on;
      end
    end
    // ---------------------------------------------------------------
    // data and parity lanes
    // ---------------------------------------------------------------
    // lanes are driven on writes only; on reads the memory owns them
    // lane enables
    doe_d = 2'b00;
    if ((is_ext || is_dram) && acc_write) begin
      doe_d = {upper_on, lower_on};
    end
    par_u_d = upper_on && acc_write &&
      ((is_dram && par_dram) || (is_ext && par_area2 && acc_area == `PARITY_AREA));
    par_l_d = lower_on && acc_write &&
      ((is_dram && par_dram) || (is_ext && par_area2 && acc_area == `PARITY_AREA));
    // ---------------------------------------------------------------
    // area 1 pin sharing
    // ---------------------------------------------------------------
    // two-column-strobe dram borrows the area 1 pin for the upper
    // column strobe; otherwise dram keeps area 1 selected throughout
    // area 1 as upper column strobe
    if (is_dram && acc_wide && !dram_two_we) begin
      area_selects_d[1] = cas_u_d;
    end else if (is_dram) begin
      area_selects_d[1] = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // output registers
  // -----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      area_selects_n <= 8'hFF;
      row_strobe_n <= 1'b1;
      column_strobe_upper_n <= 1'b1;
      column_strobe_lower_n <= 1'b1;
      read_strobe_n <= 1'b1;
      upper_lane_strobe_n <= 1'b1;
      lower_lane_strobe_n <= 1'b1;
      addr_lsb <= 1'b0;
      addr_hold_strobe_n <= 1'b1;
      data_out <= 16'h0000;
      data_oe <= 2'h0;
      upper_parity_line_out <= 1'b0;
      upper_parity_line_oe <= 1'b0;
      lower_parity_line_out <= 1'b0;
      lower_parity_line_oe <= 1'b0;
    end else begin
      area_selects_n <= area_selects_d;
      row_strobe_n <= row_d;
      column_strobe_upper_n <= cas_u_d;
      column_strobe_lower_n <= cas_l_d;
      read_strobe_n <= rd_d;
      upper_lane_strobe_n <= wru_d;
      lower_lane_strobe_n <= wrl_d;
      addr_lsb <= lsb_d;
      addr_hold_strobe_n <= ~(is_ext || is_dram);
      data_out <= wr_data;
      data_oe <= doe_d;
      upper_parity_line_out <= wr_parity[1];
      upper_parity_line_oe <= par_u_d;
      lower_parity_line_out <= wr_parity[0];
      lower_parity_line_oe <= par_l_d;
    end
  end
endmodule // ext_bus_strobe_lanes

/* File: shared/strobe_lanes_map.vh */
`ifndef STROBE_LANES_MAP_VH
`define STROBE_LANES_MAP_VH
// access kinds
`define KIND_IDLE 2'h0
`define KIND_EXT 2'h1
`define KIND_DRAM 2'h2
// byte lane codes
`define LANES_UPPER 2'h1
`define LANES_LOWER 2'h2
`define LANES_WORD 2'h3
// dram phases
`define PHASE_ROW 1'h0
`define PHASE_COL 1'h1
// parity check selection codes
`define PCHK_OFF 2'h0
`define PCHK_DRAM 2'h1
`define PCHK_AREA2 2'h2
`define PCHK_BOTH 2'h3
`define PARITY_AREA 3'h2
`define AREA_COUNT 8
`endif

/* File: rtl/lane_select.v */
`timescale 1ns/1ps
`include "strobe_lanes_map.vh"
// -----------------------------------------------------------------
// byte lane decode
// -----------------------------------------------------------------
module lane_select (
  input wire wide_space,
  input wire [1:0] lanes,
  input wire addr_lsb,
  output reg upper_on,
  output reg lower_on
);
  always @* begin
    if (wide_space) begin
      upper_on = lanes[0];
      lower_on = lanes[1];
    end else begin
      // byte-wide space carries everything on the low lane
      upper_on = 1'b0;
      lower_on = 1'b1;
    end
  end
  wire unused_lsb = addr_lsb;
endmodule // lane_select

/* File: dv/ext_bus_strobe_lanes_checker.sv */
`timescale 1ns/1ps
module strobe_checker (
  input wire clk,
  input wire rst_n,
  input wire [1:0] acc_kind,
  input wire [2:0] acc_area,
  input wire acc_wide,
  input wire [1:0] acc_lanes,
  input wire acc_write,
  input wire dram_two_we,
  input wire dram_phase,
  input wire [1:0] parity_check_sel,
  input wire [7:0] area_selects_n,
  input wire row_strobe_n,
  input wire column_strobe_upper_n,
  input wire column_strobe_lower_n,
  input wire addr_hold_strobe_n,
  input wire upper_lane_strobe_n,
  input wire upper_parity_line_oe,
  input wire lower_parity_line_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------
  // last request seen
  // ----------------
  reg [1:0] k, l, p;
  reg [2:0] a;
  reg w, r, t, d;
  always @(posedge clk) {k, a, w, l, r, t, d, p} <= {acc_kind, acc_area, acc_wide, acc_lanes, acc_write,
    dram_two_we, dram_phase, parity_check_sel};
  AST_SEL: assert property (k == 2'h1 |-> area_selects_n == ~(8'h01 << a)) else $error("sel");
  AST_ROW: assert property (k == 2'h2 |-> !row_strobe_n) else $error("row");
  AST_BYTE: assert property (k == 2'h2 && !w && d |-> column_strobe_upper_n && !column_strobe_lower_n) else $error("b");
  AST_CSU: assert property (k == 2'h2 && w && d |-> column_strobe_upper_n == !(l[0] && !t)) else $error("cu");
  AST_CSL: assert property (k == 2'h2 && d && (l[1] || w && t) |-> !column_strobe_lower_n) else $error("cl");
  AST_WRH: assert property (k == 2'h1 && !w |-> upper_lane_strobe_n) else $error("wrh");
  AST_PAR: assert property ((k == 2'h2 && d && p[0] || k == 2'h1 && a == 3'h2 && p[1]) && w && r |->
    {upper_parity_line_oe, lower_parity_line_oe} == {l[0], l[1]}) else $error("par");
  AST_AH: assert property (k != 2'h0 |-> !addr_hold_strobe_n) else $error("ah");
  AST_CS1: assert property (k == 2'h2 && w && d && !t |-> area_selects_n[1] == column_strobe_upper_n) else $error("cs1");
endmodule // strobe_checker

/* File: dv/lane_memory.sv */
`timescale 1ns/1ps
module lane_memory (
  input wire clk,
  input wire [15:0] data_out,
  input wire [1:0] data_oe,
  output wire [15:0] bus
);
  reg [15:0] last_q = 16'h0000;
  // undriven lanes toggle each cycle
  assign bus = {data_oe[1] ? data_out[15:8] : ~last_q[15:8], data_oe[0] ? data_out[7:0] : ~last_q[7:0]};
  always @(posedge clk) last_q <= bus;
endmodule // lane_memory

/* File: dv/ext_bus_strobe_lanes_bench.sv */
`timescale 1ns/1ps
module ext_bus_strobe_lanes_bench;
  reg clk = 0, rst_n = 0, acc_wide = 0, acc_write = 0, acc_hbs_mode = 0, dram_two_we = 0, dram_phase = 0;
  reg addr_lsb_in = 0;
  reg [1:0] acc_kind = 0, acc_lanes = 2'h2, parity_check_sel = 0, wr_parity = 0;
  reg [2:0] acc_area = 0;
  reg [15:0] wr_data = 0;
  wire [7:0] area_selects_n;
  wire row_strobe_n, column_strobe_upper_n, column_strobe_lower_n, read_strobe_n, upper_lane_strobe_n;
  wire lower_lane_strobe_n, addr_lsb, addr_hold_strobe_n, upper_parity_line_out, upper_parity_line_oe;
  wire lower_parity_line_out, lower_parity_line_oe;
  wire [1:0] data_oe;
  wire [15:0] data_out, bus;
  reg [36:0] q[$];
  reg [36:0] e;
  integer bad_count = 0, n_checks = 0, i;
  ext_bus_strobe_lanes dut_u (.*);
  lane_memory mem_u (.clk(clk), .data_out(data_out), .data_oe(data_oe), .bus(bus));
  initial forever #20 clk = ~clk;
  task check(input string nm, input [15:0] seen, input [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task drive(input [1:0] k, input [2:0] a, input w, input [1:0] l, input r, input t, input d);
    reg [1:0] n, x;
    reg [3:0] s;
    @(negedge clk);
    n = w ? (l == 2'h0 ? 2'h3 : l) : 2'h2;
    x = r && k != 2'h0 ? (w ? {n[0], n[1]} : 2'h1) : 2'h0;
    {acc_kind, acc_area, acc_wide, acc_lanes, acc_write, dram_two_we, dram_phase} = {k, a, w, n, r, t, d};
    {wr_data, parity_check_sel, acc_hbs_mode, addr_lsb_in, wr_parity} = $urandom;
    s = {!(k != 2'h0 && !r), 2'b11, addr_lsb_in};
    if (k == 2'h2 && r) s[2:1] = (w && t) ? {!n[0], !n[1]} : 2'b10;
    else if (k == 2'h1 && !w) s[2:1] = {1'b1, !r};
    else if (k == 2'h1 && acc_hbs_mode) s[2:0] = {!n[1], !r, !n[0]};
    else if (k == 2'h1 && r) s[2:1] = {!n[0], !n[1]};
    q.push_back({s, wr_parity, k == 2'h1, k == 2'h2 && d, k != 2'h2 || d, ~(8'h01 << a),
      !(w && n[0] && !t), !(n[1] || (w && t)), x, wr_data & {{8{x[1]}}, {8{x[0]}}}});
  endtask
  // ----------------
  // result monitor
  // ----------------
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      check("rd wrh wrl lsb", {12'h000, read_strobe_n, upper_lane_strobe_n, lower_lane_strobe_n, addr_lsb},
        {12'h000, e[36:33]});
      check("parity out", {14'h0000, upper_parity_line_out, lower_parity_line_out}, {14'h0000, e[32:31]});
      if (e[30]) check("area_selects_n", {8'h00, area_selects_n}, {8'h00, e[27:20]});
      if (e[29]) check("column strobes", {14'h0000, column_strobe_upper_n, column_strobe_lower_n}, {14'h0000, e[19:18]});
      if (e[28]) check("data_oe", {14'h0000, data_oe}, {14'h0000, e[17:16]});
      if (e[28]) check("data lanes", bus & {{8{e[17]}}, {8{e[16]}}}, e[15:0]);
    end
  end
  initial begin
    void'($urandom(44));
    repeat (6) @(negedge clk);
    rst_n = 1;
    for (i = 0; i < 8; i = i + 1) drive(2'h1, i, 1'b1, 2'h3, 1'b1, 1'b0, 1'b0);
    $display("area select test done");
    for (i = 0; i < 400; i = i + 1) drive($urandom % 3, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom);
    repeat (3) @(negedge clk);
    $display("random access test done");
    report_and_stop;
  end
  initial begin
    #40000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule // ext_bus_strobe_lanes_bench
bind ext_bus_strobe_lanes strobe_checker chk_u (.*);
